// File: ifep_pkg.sv
// package: register map, field layout and reset values of the interrupt flag/enable/priority slice
//
// Functional notes
// - flag reads one after request, software writable
// - priority code 111 means level seven
// - code 001 lowest, 000 disables source
// - unimplemented bits ignore writes, read zero
// - external 1/2 need mapped remappable pin; the code gates only ext2, by pin_map[1]
// - flag register holds listed source flags
// - enable register holds listed source enables
// - priority fields at 14-12,10-8,6-4,2-0
package ifep_pkg;
   // ***********************************************************************
   // register byte offsets
   // ***********************************************************************
   localparam logic [11:0] OFS_FLAG       = 12'h000;
   localparam logic [11:0] OFS_ENABLE     = 12'h004;
   localparam logic [11:0] OFS_PRIORITY   = 12'h008;
   localparam logic [11:0] OFS_PIN_MAP    = 12'h00C;
   localparam logic [11:0] OFS_IRQ_STATUS = 12'h010;
   localparam logic [11:0] OFS_IRQ_MASK   = 12'h014;
   localparam logic [11:0] OFS_REQUEST    = 12'h018;
   // ***********************************************************************
   // implemented bit masks and reset values
   // ***********************************************************************
   localparam logic [15:0] FLAG_MASK      = 16'h7DE6;
   localparam logic [15:0] ENABLE_MASK    = 16'hFF1F;
   localparam logic [15:0] PRIORITY_MASK  = 16'h7777;
   localparam logic [15:0] FLAG_RESET     = 16'h0000;
   localparam logic [15:0] ENABLE_RESET   = 16'h0000;
   localparam logic [15:0] PRIORITY_RESET = 16'h4444;
   localparam logic [1:0]  PIN_MAP_MASK   = 2'h3;
   // ***********************************************************************
   // flag bit positions
   // ***********************************************************************
   localparam int FLAG_CALENDAR  = 14;
   localparam int FLAG_DMA5      = 13;
   localparam int FLAG_SER3_RX   = 12;
   localparam int FLAG_SER2_RX   = 11;
   localparam int FLAG_SER1_RX   = 10;
   localparam int FLAG_KEY_STORE = 8;
   localparam int FLAG_CRYPTO    = 7;
   localparam int FLAG_EXT4      = 6;
   localparam int FLAG_EXT3      = 5;
   localparam int FLAG_TW2_MST   = 2;
   localparam int FLAG_TW2_SLV   = 1;
   // ***********************************************************************
   // enable bit positions
   // ***********************************************************************
   localparam int EN_UART_B_TX = 15;
   localparam int EN_UART_B_RX = 14;
   localparam int EN_EXT2      = 13;
   localparam int EN_TIMER5    = 12;
   localparam int EN_EXT1      = 4;
   // ***********************************************************************
   // priority field positions (low bit of each 3-bit field)
   // ***********************************************************************
   localparam int PRI_UART_B_TX = 12;
   localparam int PRI_UART_B_RX = 8;
   localparam int PRI_EXT2      = 4;
   localparam int PRI_TIMER5    = 0;
   localparam int NUM_PRI_SRC   = 4;
   localparam logic [2:0] PRI_OFF = 3'h0;
endpackage : ifep_pkg

// File: ifep_source_gate.sv
// module: one prioritised source gate
`timescale 1ns/1ps
module ifep_source_gate
(
   input  wire logic       flag,
   input  wire logic       enable,
   input  wire logic       pin_ok,
   input  wire logic [2:0] level,
   output logic            request,
   output logic [2:0]      req_level
);
   always_comb
   begin
      request   = flag & enable & pin_ok & (level != ifep_pkg::PRI_OFF);
      req_level = request ? level : ifep_pkg::PRI_OFF;
   end
endmodule : ifep_source_gate

// File: ifep_src_model.sv
// peripheral source model: flag pulses and pending request levels
`timescale 1ns/1ps
module ifep_src_model
(
   input  wire logic        clock,
   input  wire logic        rst_n,
   input  wire logic [15:0] fire,
   input  wire logic [15:0] pend,
   output logic      [15:0] flag_set,
   output logic      [15:0] src_event
);
   // sources change their lines just after an edge, like real peripherals
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         flag_set  <= 16'h0;
         src_event <= 16'h0;
      end
      else
      begin
         flag_set  <= fire;
         src_event <= pend;
      end
   end
endmodule : ifep_src_model

// File: ifep_top.sv
// module: flag, enable and priority registers with APB slave and prioritised request outputs
//
// Our own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
module ifep_top
(
   input  wire logic        CLOCK,
   input  wire logic        RST_N,
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [11:0] PADDR,
   input  wire logic [31:0] PWDATA,
   output logic             PREADY,
   output logic [31:0]      PRDATA,
   output logic             PSLVERR,
   input  wire logic [15:0] FLAG_SET,
   input  wire logic [15:0] SRC_ENABLE_EVENT,
   output logic [3:0]       SRC_REQUEST,
   output logic [11:0]      SRC_LEVEL,
   output logic [2:0]       TOP_LEVEL,
   output logic             IRQ
);
   // ***********************************************************************
   // decode helpers
   // ***********************************************************************
   function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
      hit = (a == ofs);
   endfunction : hit

   logic [15:0] flag_reg;
   logic [15:0] enable_reg;
   logic [15:0] priority_reg;
   logic [1:0]  pin_map;
   logic [3:0]  irq_status;
   logic [3:0]  irq_mask;
   logic [31:0] rdata;
   logic [15:0] next_flag_reg;
   logic [15:0] next_enable_reg;
   logic [15:0] next_priority_reg;
   logic [1:0]  next_pin_map;
   logic [3:0]  next_irq_status;
   logic [3:0]  next_irq_mask;
   logic [31:0] next_rdata;
   logic        wr;
   logic        rd;
   logic        mapped;
   logic [3:0]  req;
   logic [11:0] lvl;
   logic [3:0]  req_q;
   logic [3:0]  next_req_q;
   logic [2:0]  best;

   // ***********************************************************************
   // apb access
   // ***********************************************************************
   assign wr      = PSEL & PENABLE & PWRITE;
   assign rd      = PSEL & ~PENABLE & ~PWRITE;
   assign PREADY  = 1'b1;
   assign PSLVERR = PSEL & PENABLE & ~mapped;
   assign PRDATA  = rdata;

   always_comb
   begin
      mapped = hit(PADDR, ifep_pkg::OFS_FLAG) | hit(PADDR, ifep_pkg::OFS_ENABLE)
             | hit(PADDR, ifep_pkg::OFS_PRIORITY) | hit(PADDR, ifep_pkg::OFS_PIN_MAP)
             | hit(PADDR, ifep_pkg::OFS_IRQ_STATUS) | hit(PADDR, ifep_pkg::OFS_IRQ_MASK)
             | hit(PADDR, ifep_pkg::OFS_REQUEST);
   end

   // ***********************************************************************
   // register next values
   // ***********************************************************************
   always_comb
   begin
      next_flag_reg     = flag_reg;
      next_enable_reg   = enable_reg;
      next_priority_reg = priority_reg;
      next_pin_map      = pin_map;
      next_irq_mask     = irq_mask;
      next_irq_status   = irq_status;
      if (wr && hit(PADDR, ifep_pkg::OFS_FLAG))
         next_flag_reg = PWDATA[15:0] & ifep_pkg::FLAG_MASK;
      if (wr && hit(PADDR, ifep_pkg::OFS_ENABLE))
         next_enable_reg = PWDATA[15:0] & ifep_pkg::ENABLE_MASK;
      if (wr && hit(PADDR, ifep_pkg::OFS_PRIORITY))
         next_priority_reg = PWDATA[15:0] & ifep_pkg::PRIORITY_MASK;
      if (wr && hit(PADDR, ifep_pkg::OFS_PIN_MAP))
         next_pin_map = PWDATA[1:0] & ifep_pkg::PIN_MAP_MASK;
      if (wr && hit(PADDR, ifep_pkg::OFS_IRQ_MASK))
         next_irq_mask = PWDATA[3:0];
      if (wr && hit(PADDR, ifep_pkg::OFS_IRQ_STATUS))
         next_irq_status = irq_status & ~PWDATA[3:0];
      // hardware set wins over software write
      next_flag_reg   = next_flag_reg | (FLAG_SET & ifep_pkg::FLAG_MASK);
      next_irq_status = next_irq_status | (req & ~req_q);
      next_req_q      = req;
   end

   always_comb
   begin
      next_rdata = 32'h0000_0000;
      if (rd)
      begin
         if (hit(PADDR, ifep_pkg::OFS_FLAG))
            next_rdata[15:0] = flag_reg;
         else if (hit(PADDR, ifep_pkg::OFS_ENABLE))
            next_rdata[15:0] = enable_reg;
         else if (hit(PADDR, ifep_pkg::OFS_PRIORITY))
            next_rdata[15:0] = priority_reg;
         else if (hit(PADDR, ifep_pkg::OFS_PIN_MAP))
            next_rdata[1:0] = pin_map;
         else if (hit(PADDR, ifep_pkg::OFS_IRQ_STATUS))
            next_rdata[3:0] = irq_status;
         else if (hit(PADDR, ifep_pkg::OFS_IRQ_MASK))
            next_rdata[3:0] = irq_mask;
         else if (hit(PADDR, ifep_pkg::OFS_REQUEST))
            next_rdata[6:0] = {best, req};
      end
      else
         next_rdata = rdata;
   end

   always_ff @(posedge CLOCK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         flag_reg     <= ifep_pkg::FLAG_RESET;
         enable_reg   <= ifep_pkg::ENABLE_RESET;
         priority_reg <= ifep_pkg::PRIORITY_RESET;
         pin_map      <= 2'h0;
         irq_status   <= 4'h0;
         irq_mask     <= 4'h0;
         rdata        <= 32'h0000_0000;
         req_q        <= 4'h0;
      end
      else
      begin
         flag_reg     <= next_flag_reg;
         enable_reg   <= next_enable_reg;
         priority_reg <= next_priority_reg;
         pin_map      <= next_pin_map;
         irq_status   <= next_irq_status;
         irq_mask     <= next_irq_mask;
         rdata        <= next_rdata;
         req_q        <= next_req_q;
      end
   end

   // ***********************************************************************
   // prioritised sources
   // ***********************************************************************
   // source 0 timer5, 1 ext2, 2 uart rx, 3 uart tx; flags from SRC_ENABLE_EVENT levels
   localparam int EN_POS [4] = '{ifep_pkg::EN_TIMER5, ifep_pkg::EN_EXT2,
                                 ifep_pkg::EN_UART_B_RX, ifep_pkg::EN_UART_B_TX};
   localparam int PR_POS [4] = '{ifep_pkg::PRI_TIMER5, ifep_pkg::PRI_EXT2,
                                 ifep_pkg::PRI_UART_B_RX, ifep_pkg::PRI_UART_B_TX};
   genvar g;
   generate
      for (g = 0; g < ifep_pkg::NUM_PRI_SRC; g++)
      begin : g_src
         ifep_source_gate u_gate
         (
            .flag      (SRC_ENABLE_EVENT[EN_POS[g]]),
            .enable    (enable_reg[EN_POS[g]]),
            .pin_ok    ((g == 1) ? pin_map[1] : 1'b1),
            .level     (priority_reg[PR_POS[g] +: 3]),
            .request   (req[g]),
            .req_level (lvl[g*3 +: 3])
         );
      end
   endgenerate

   always_comb
   begin
      best = ifep_pkg::PRI_OFF;
      for (int i = 0; i < ifep_pkg::NUM_PRI_SRC; i++)
         if (lvl[i*3 +: 3] > best)
            best = lvl[i*3 +: 3];
   end

   assign SRC_REQUEST = req;
   assign SRC_LEVEL   = lvl;
   assign TOP_LEVEL   = best;
   assign IRQ         = |(irq_status & irq_mask);

   // ***********************************************************************
   // checks
   // ***********************************************************************
   sequence s_flag_wr;
      wr && (PADDR == ifep_pkg::OFS_FLAG) && (FLAG_SET == 16'h0000);
   endsequence
   sequence s_no_flag_wr;
      !(wr && (PADDR == ifep_pkg::OFS_FLAG));
   endsequence
   sequence s_pri_rd;
      PSEL && !PENABLE && !PWRITE && (PADDR == ifep_pkg::OFS_PRIORITY);
   endsequence
   sequence s_req_rd;
      PSEL && !PENABLE && !PWRITE && (PADDR == ifep_pkg::OFS_REQUEST);
   endsequence
   sequence s_unmapped_rd;
      PSEL && !PENABLE && !PWRITE && !mapped;
   endsequence
   sequence s_req0_rise;
      !req[0] ##1 req[0];
   endsequence
   sequence s_status0_clr;
      wr && (PADDR == ifep_pkg::OFS_IRQ_STATUS) && PWDATA[0] && !(req[0] && !req_q[0]);
   endsequence

   // ***********************************************************************
   // reset and register checks
   // ***********************************************************************
   AST_PRI_RESET: assert property (@(posedge CLOCK)
      $rose(RST_N) |-> priority_reg == ifep_pkg::PRIORITY_RESET)
      else $error("priority reset wrong");
   AST_FLAG_RESET: assert property (@(posedge CLOCK)
      $rose(RST_N) |-> (flag_reg == ifep_pkg::FLAG_RESET) && (enable_reg == 16'h0000))
      else $error("flag or enable reset wrong");
   AST_UNIMP: assert property (@(posedge CLOCK) disable iff (!RST_N)
      ((flag_reg & ~ifep_pkg::FLAG_MASK) == 16'h0000)
      && ((enable_reg & ~ifep_pkg::ENABLE_MASK) == 16'h0000))
      else $error("unimplemented bit set");
   AST_PRI_UNIMP: assert property (@(posedge CLOCK) disable iff (!RST_N)
      (priority_reg & ~ifep_pkg::PRIORITY_MASK) == 16'h0000)
      else $error("unused priority bit set");
   AST_FLAG_SET: assert property (@(posedge CLOCK) disable iff (!RST_N)
      FLAG_SET[ifep_pkg::FLAG_CRYPTO] |=> flag_reg[ifep_pkg::FLAG_CRYPTO])
      else $error("flag not set");
   AST_FLAG_WR: assert property (@(posedge CLOCK) disable iff (!RST_N)
      s_flag_wr |=> flag_reg == ($past(PWDATA[15:0]) & ifep_pkg::FLAG_MASK))
      else $error("flag write wrong");
   AST_STICKY: assert property (@(posedge CLOCK) disable iff (!RST_N)
      s_no_flag_wr |=> (flag_reg & $past(flag_reg)) == $past(flag_reg))
      else $error("flag lost without write");
   AST_EN_WR: assert property (@(posedge CLOCK) disable iff (!RST_N)
      wr && (PADDR == ifep_pkg::OFS_ENABLE) |=> enable_reg == ($past(PWDATA[15:0]) & 16'hFF1F))
      else $error("enable write wrong");
   AST_PRI_WR: assert property (@(posedge CLOCK) disable iff (!RST_N)
      wr && (PADDR == ifep_pkg::OFS_PRIORITY)
      |=> priority_reg == ($past(PWDATA[15:0]) & ifep_pkg::PRIORITY_MASK))
      else $error("priority write");
   AST_PIN_WR: assert property (@(posedge CLOCK) disable iff (!RST_N)
      wr && (PADDR == ifep_pkg::OFS_PIN_MAP) |=> pin_map == $past(PWDATA[1:0]))
      else $error("pin map write wrong");
   AST_RD_PRI: assert property (@(posedge CLOCK) disable iff (!RST_N)
      s_pri_rd |=> PRDATA == {16'h0000, $past(priority_reg)})
      else $error("priority read wrong");
   AST_UNMAP_RD: assert property (@(posedge CLOCK) disable iff (!RST_N)
      s_unmapped_rd |=> PRDATA == 32'h0000_0000)
      else $error("unmapped read not zero");

   // ***********************************************************************
   // request checks
   // ***********************************************************************
   AST_ZERO_OFF: assert property (@(posedge CLOCK) disable iff (!RST_N)
      (priority_reg[2:0] == ifep_pkg::PRI_OFF) |-> !req[0])
      else $error("code 000 not off");
   AST_TX_OFF: assert property (@(posedge CLOCK) disable iff (!RST_N)
      (priority_reg[14:12] == ifep_pkg::PRI_OFF) |-> !req[3])
      else $error("code 000 not off on uart tx");
   AST_EN_GATE: assert property (@(posedge CLOCK) disable iff (!RST_N)
      !enable_reg[ifep_pkg::EN_UART_B_TX] |-> !req[3])
      else $error("disabled source requests");
   AST_PIN_GATE: assert property (@(posedge CLOCK) disable iff (!RST_N)
      !pin_map[1] |-> !req[1])
      else $error("unmapped ext2 requests");
   AST_LEVEL7: assert property (@(posedge CLOCK) disable iff (!RST_N)
      req[0] && (priority_reg[2:0] == 3'h7) |-> TOP_LEVEL == 3'h7)
      else $error("level 7 not top");
   AST_REQ: assert property (@(posedge CLOCK) disable iff (!RST_N)
      req[2] |-> (SRC_LEVEL[8:6] == priority_reg[10:8]) && enable_reg[14])
      else $error("request level wrong");
   AST_TOP_BOUND: assert property (@(posedge CLOCK) disable iff (!RST_N)
      req[1] |-> TOP_LEVEL >= lvl[5:3])
      else $error("top level below a request");
   AST_REQ_RD: assert property (@(posedge CLOCK) disable iff (!RST_N)
      s_req_rd |=> PRDATA == {25'h0, $past(best), $past(req)})
      else $error("request read wrong");
   generate
      for (g = 0; g < ifep_pkg::NUM_PRI_SRC; g++)
      begin : g_chk
         AST_GATE: assert property (@(posedge CLOCK) disable iff (!RST_N)
            req[g] |-> enable_reg[EN_POS[g]] && (priority_reg[PR_POS[g] +: 3] != 3'h0))
            else $error("request without enable or level");
         AST_LVL_MATCH: assert property (@(posedge CLOCK) disable iff (!RST_N)
            req[g] |-> lvl[g*3 +: 3] == priority_reg[PR_POS[g] +: 3])
            else $error("request level differs from field");
         AST_LVL_IDLE: assert property (@(posedge CLOCK) disable iff (!RST_N)
            !req[g] |-> lvl[g*3 +: 3] == ifep_pkg::PRI_OFF)
            else $error("level shown without request");
      end
   endgenerate

   // ***********************************************************************
   // interrupt checks
   // ***********************************************************************
   AST_STATUS_SET: assert property (@(posedge CLOCK) disable iff (!RST_N)
      s_req0_rise |=> irq_status[0])
      else $error("status not set on request");
   AST_STATUS_CLR: assert property (@(posedge CLOCK) disable iff (!RST_N)
      s_status0_clr |=> !irq_status[0])
      else $error("status not cleared");
   AST_MASK_WR: assert property (@(posedge CLOCK) disable iff (!RST_N)
      wr && (PADDR == ifep_pkg::OFS_IRQ_MASK) |=> irq_mask == $past(PWDATA[3:0]))
      else $error("mask write wrong");
   AST_IRQ_OFF: assert property (@(posedge CLOCK) disable iff (!RST_N)
      (irq_mask == 4'h0) |-> !IRQ)
      else $error("masked interrupt raised");
endmodule : ifep_top

// File: tb_interrupt_flag_enable_priority.sv
// testbench: register access, request gating and interrupt of the flag slice
`timescale 1ns/1ps
module tb_interrupt_flag_enable_priority;
   typedef struct packed {logic [11:0] a; logic w; logic [31:0] d; logic [31:0] e; logic r;}
      ifep_row_t;
   typedef struct packed {logic [31:0] p; logic [31:0] pr; logic [31:0] en; logic [18:0] x;}
      ifep_gate_t;
   logic        clock, rst_n, psel, penable, pwrite, pready, pslverr, irq, er;
   logic [11:0] paddr, lvl;
   logic [31:0] pwdata, prdata, rd;
   logic [15:0] fire, pend, flag_set, src_event;
   logic [3:0]  req;
   logic [2:0]  top;
   int          fail_count, total_checks, cycles;
   localparam ifep_row_t ROWS [0:7] = '{
      '{ifep_pkg::OFS_FLAG, 1'b0, 32'h0, 32'h0, 1'b0},
      '{ifep_pkg::OFS_ENABLE, 1'b0, 32'h0, 32'h0, 1'b0},
      '{ifep_pkg::OFS_PRIORITY, 1'b0, 32'h0, 32'h4444, 1'b0},
      '{ifep_pkg::OFS_FLAG, 1'b1, 32'hFFFF, 32'h7DE6, 1'b0},
      '{ifep_pkg::OFS_ENABLE, 1'b1, 32'hFFFF, 32'hFF1F, 1'b0},
      '{ifep_pkg::OFS_PRIORITY, 1'b1, 32'hFFFF, 32'h7777, 1'b0},
      '{ifep_pkg::OFS_PRIORITY, 1'b1, 32'hFFFF_0000, 32'h0, 1'b0},
      '{12'h020, 1'b1, 32'hFFFF, 32'h0, 1'b1}};
   // pin map, priority, enable, then expected {top, request, levels}
   localparam ifep_gate_t GATE [0:6] = '{
      '{32'h3, 32'h7531, 32'hF000, {3'h7, 4'hF, 12'hF59}},
      '{32'h3, 32'h7531, 32'h7000, {3'h5, 4'h7, 12'h159}},
      '{32'h3, 32'h7031, 32'hF000, {3'h7, 4'hB, 12'hE19}},
      '{32'h1, 32'h7031, 32'hF000, {3'h7, 4'h9, 12'hE01}},
      '{32'h3, 32'h1117, 32'hF000, {3'h7, 4'hF, 12'h24F}},
      '{32'h3, 32'h7770, 32'hF000, {3'h7, 4'hE, 12'hFF8}},
      '{32'h3, 32'h1111, 32'hF000, {3'h1, 4'hF, 12'h249}}};

   ifep_src_model model (.clock(clock), .rst_n(rst_n), .fire(fire), .pend(pend),
      .flag_set(flag_set), .src_event(src_event));
   ifep_top dut (.CLOCK(clock), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PREADY(pready), .PRDATA(prdata),
      .PSLVERR(pslverr), .FLAG_SET(flag_set), .SRC_ENABLE_EVENT(src_event),
      .SRC_REQUEST(req), .SRC_LEVEL(lvl), .TOP_LEVEL(top), .IRQ(irq));
   // ****************************************
   // bus and compare tasks
   // ****************************************
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clock);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      do
      begin
         @(posedge clock);
         n++;
      end
      while (pready !== 1'b1 && n < 50);
      if (n == 50)
         fail_count++;
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         fail_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic finish_test();
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : finish_test
   // ****************************************
   // clock, timeout
   // ****************************************
   initial
   begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end
   always @(posedge clock)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         fail_count++;
         finish_test();
      end
   end
   // ****************************************
   // tests
   // ****************************************
   initial
   begin
      {rst_n, psel, penable, pwrite, paddr, pwdata, fire, pend} = '0;
      repeat (2) @(posedge clock);
      rst_n <= 1'b1;
      foreach (ROWS[i])
      begin
         if (ROWS[i].w)
            apb(1'b1, ROWS[i].a, ROWS[i].d);
         apb(1'b0, ROWS[i].a, 32'h0);
         chk(rd, ROWS[i].e);
         chk({31'h0, er}, {31'h0, ROWS[i].r});
      end
      $display("register map test done");
      pend <= 16'hF000;
      foreach (GATE[i])
      begin
         apb(1'b1, ifep_pkg::OFS_PIN_MAP, GATE[i].p);
         apb(1'b1, ifep_pkg::OFS_PRIORITY, GATE[i].pr);
         apb(1'b1, ifep_pkg::OFS_ENABLE, GATE[i].en);
         @(negedge clock);
         chk({13'h0, top, req, lvl}, {13'h0, GATE[i].x});
      end
      $display("request gating test done");
      apb(1'b1, ifep_pkg::OFS_FLAG, 32'h0);
      fire <= 16'hFFFF;
      @(posedge clock);
      fire <= 16'h0;
      repeat (2) @(posedge clock);
      apb(1'b0, ifep_pkg::OFS_FLAG, 32'h0);
      chk(rd, 32'h7DE6);
      $display("flag set test done");
      pend <= 16'h0;
      repeat (3) @(posedge clock);
      apb(1'b1, ifep_pkg::OFS_IRQ_STATUS, 32'hF);
      apb(1'b1, ifep_pkg::OFS_IRQ_MASK, 32'h0);
      pend <= 16'h1000;
      repeat (3) @(posedge clock);
      apb(1'b0, ifep_pkg::OFS_IRQ_STATUS, 32'h0);
      chk(rd, 32'h1);
      chk({31'h0, irq}, 32'h0);
      apb(1'b1, ifep_pkg::OFS_IRQ_MASK, 32'h1);
      @(negedge clock);
      chk({31'h0, irq}, 32'h1);
      apb(1'b1, ifep_pkg::OFS_IRQ_STATUS, 32'h1);
      @(negedge clock);
      chk({31'h0, irq}, 32'h0);
      $display("interrupt test done");
      @(posedge clock);
      rst_n <= 1'b0;
      repeat (2) @(posedge clock);
      chk({31'h0, irq}, 32'h0);
      rst_n <= 1'b1;
      apb(1'b0, ifep_pkg::OFS_PRIORITY, 32'h0);
      chk(rd, 32'h4444);
      apb(1'b0, ifep_pkg::OFS_ENABLE, 32'h0);
      chk(rd, 32'h0);
      $display("reset test done");
      finish_test();
   end
endmodule : tb_interrupt_flag_enable_priority
